// ==== rtl/stepper_out_cfg.svh ====
`ifndef STEPPER_OUT_CFG_SVH
`define STEPPER_OUT_CFG_SVH
// step pulse base unit: 16 system clocks per divider step
`define STEP_UNIT_CYCLES        16
// step pulse rate never above mclk / 32
`define STEP_MIN_PERIOD_CYCLES  32
// serial clock half period is (divider+1) clocks, divider 7..255
`define SCK_DIV_MIN             8'h07
`define SCK_DIV_RESET           8'h0F
// datagram length field 0..63 means 1..64 bits
`define FRAME_LEN_RESET         6'h3F
`define CFG_WORDS               64
`define NUM_DRIVERS             3
`endif

// ==== rtl/stepper_out_pkg.sv ====
`default_nettype none
package stepper_out_pkg;
  typedef enum logic [2:0] {
    SER_IDLE  = 3'b000,
    SER_SETUP = 3'b001,
    SER_LOW   = 3'b011,
    SER_HIGH  = 3'b010,
    SER_HOLD  = 3'b110
  } ser_state_t;
endpackage : stepper_out_pkg
`default_nettype wire

// ==== rtl/step_pulse_gen.sv ====
`include "stepper_out_cfg.svh"
`default_nettype none
module step_pulse_gen (
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic       enable_in,
  input  wire logic [3:0] step_pulse_divider_in,
  input  wire logic       step_req_in,
  input  wire logic       dir_req_in,
  output logic            step_busy_out,
  output logic            step_out,
  output logic            dir_out
);
  logic [8:0] cnt;
  logic [8:0] next_cnt;
  logic [8:0] gap;
  logic [8:0] next_gap;
  logic       next_step;
  logic       next_dir;
  logic       dir_wait;
  logic       next_dir_wait;
  logic [8:0] plen;

  assign plen = 9'(`STEP_UNIT_CYCLES * (32'(step_pulse_divider_in) + 1));
  assign step_busy_out = step_out | (gap != 9'h000) | dir_wait | (cnt != 9'h000);

  always_comb begin
    next_cnt      = cnt;
    next_gap      = gap;
    next_step     = step_out;
    next_dir      = dir_out;
    next_dir_wait = dir_wait;
    if (gap != 9'h000) begin
      next_gap = gap - 9'h001;
    end
    if (cnt != 9'h000) begin
      next_cnt = cnt - 9'h001;
      if (cnt == 9'h001) begin
        next_step     = 1'b0;
        next_dir_wait = 1'b0;
      end
    end else if (enable_in && step_req_in && gap == 9'h000) begin
      if (dir_req_in != dir_out) begin
        next_dir      = dir_req_in;
        next_dir_wait = 1'b1;
        next_cnt      = plen;
      end else begin
        next_step = 1'b1;
        next_cnt  = plen;
        next_gap  = (plen < 9'(`STEP_MIN_PERIOD_CYCLES)) ? 9'(`STEP_MIN_PERIOD_CYCLES) : 9'h000;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt      <= 9'h000;
      gap      <= 9'h000;
      step_out <= 1'b0;
      dir_out  <= 1'b0;
      dir_wait <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      gap      <= next_gap;
      step_out <= next_step;
      dir_out  <= next_dir;
      dir_wait <= next_dir_wait;
    end
  end
endmodule : step_pulse_gen
`default_nettype wire

// ==== rtl/stepper_driver_output_port.sv ====
// Behaviour
// - select bit 1 gives step/direction, 0 gives serial driver chain
// - step/direction mode leaves sequencer and datagram table unused
// - step pulse lasts 16 times (divider plus one) clocks
// - first step after direction change waits one pulse length
// - step rate never exceeds clock divided by 32
// - serial mode drives control signals for up to three drivers
// - bit order of each driver's datagram is configurable per driver
// - layout table holds 64 config values in 32 addresses
// - datagrams are sent autonomously once initialised
// - last chip in the chain is driver 0
// - serial clock period programmable from 16 to 512 clocks
// - default serial clock is 16 low plus 16 high
// - divider 7 gives shortest period of 8 plus 8
// - chip select and serial clock polarities programmable
// - datagram is 1 to 64 bits inside one chip select
`include "stepper_out_cfg.svh"
`default_nettype none
module stepper_driver_output_port (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        step_dir_select_in,
  input  wire logic [3:0]  secondary_clock_divider_in,
  input  wire logic        step_req_in,
  input  wire logic        dir_req_in,
  input  wire logic [7:0]  sck_divider_in,
  input  wire logic        cs_active_high_in,
  input  wire logic        sck_idle_high_in,
  input  wire logic [5:0]  frame_len_in,
  input  wire logic        cfg_we_in,
  input  wire logic [4:0]  cfg_addr_in,
  input  wire logic [11:0] cfg_data_in,
  input  wire logic        chain_enable_in,
  input  wire logic [2:0]  signal_bits_in [0:2][0:31],
  input  wire logic        driver_chain_input_in,
  output logic             step_out,
  output logic             dir_out,
  output logic             step_busy_out,
  output logic             driver_chip_select_n_out,
  output logic             driver_clock_out,
  output logic             driver_chain_output_out,
  output logic [63:0]      chain_readback_out,
  output logic             frame_done_out
);
  // ==========================================================
  // step/direction path
  // ==========================================================
  logic step_i;
  logic dir_i;
  logic busy_i;

  step_pulse_gen i_step_pulse_gen (
    .mclk_in              (mclk_in),
    .rst_in               (rst_in),
    .enable_in            (step_dir_select_in),
    .step_pulse_divider_in(secondary_clock_divider_in),
    .step_req_in          (step_req_in),
    .dir_req_in           (dir_req_in),
    .step_busy_out        (busy_i),
    .step_out             (step_i),
    .dir_out              (dir_i)
  );

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      step_out      <= 1'b0;
      dir_out       <= 1'b0;
      step_busy_out <= 1'b0;
    end else begin
      step_out      <= step_i;
      dir_out       <= dir_i;
      step_busy_out <= busy_i;
    end
  end

  // ==========================================================
  // datagram layout table
  // ==========================================================
  // each word: [11] next-driver, [10:6] code odd, [5] next-driver, [4:0] code even
  // 64 values in 32 words
  logic [11:0] cfg_mem [0:31];

  always_ff @(posedge mclk_in) begin
    if (cfg_we_in) begin
      cfg_mem[cfg_addr_in] <= cfg_data_in;
    end
  end

  // ==========================================================
  // pin synchroniser
  // ==========================================================
  logic sdi_s1;
  logic sdi_s2;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
    end else begin
      sdi_s1 <= driver_chain_input_in;
      sdi_s2 <= sdi_s1;
    end
  end

  // ==========================================================
  // serial chain engine
  // ==========================================================
  stepper_out_pkg::ser_state_t st;
  stepper_out_pkg::ser_state_t next_st;
  logic [7:0]  tcnt;
  logic [7:0]  next_tcnt;
  logic [5:0]  bidx;
  logic [5:0]  next_bidx;
  logic [1:0]  drv;
  logic [1:0]  next_drv;
  logic [63:0] rx;
  logic [63:0] next_rx;
  logic        sdo;
  logic        next_sdo;
  logic        done;
  logic        next_done;
  logic [7:0]  half;
  logic [11:0] word;
  logic [5:0]  entry;
  logic [4:0]  code;
  logic        nxm;

  function automatic logic [7:0] clamp_div(input logic [7:0] d);
    clamp_div = (d < `SCK_DIV_MIN) ? `SCK_DIV_MIN : d;
  endfunction : clamp_div

  assign half  = clamp_div(sck_divider_in);
  assign word  = cfg_mem[bidx[5:1]];
  assign entry = bidx[0] ? word[11:6] : word[5:0];
  assign nxm   = entry[5];
  assign code  = entry[4:0];

  // first bits go to farthest chip, driver 0
  function automatic logic pick_bit(input logic [4:0] c, input logic [1:0] d,
                                    input logic [2:0] sig [0:2][0:31]);
    logic [1:0] dd;
    dd = (d > 2'h2) ? 2'h2 : d;
    pick_bit = sig[dd][c][0];
  endfunction : pick_bit

  always_comb begin
    next_st   = st;
    next_tcnt = tcnt;
    next_bidx = bidx;
    next_drv  = drv;
    next_rx   = rx;
    next_sdo  = sdo;
    next_done = 1'b0;
    unique case (st)
      stepper_out_pkg::SER_IDLE: begin
        if (!step_dir_select_in && chain_enable_in) begin
          next_st   = stepper_out_pkg::SER_SETUP;
          next_tcnt = half;
          next_bidx = 6'h00;
          next_drv  = 2'h0;
          next_rx   = 64'h0;
          next_sdo  = pick_bit(code, 2'h0, signal_bits_in);
        end
      end
      stepper_out_pkg::SER_SETUP: begin
        if (tcnt == 8'h00) begin
          next_st   = stepper_out_pkg::SER_LOW;
          next_tcnt = half;
        end else begin
          next_tcnt = tcnt - 8'h01;
        end
      end
      stepper_out_pkg::SER_LOW: begin
        if (tcnt == 8'h00) begin
          next_st   = stepper_out_pkg::SER_HIGH;
          next_tcnt = half;
          next_rx   = {rx[62:0], sdi_s2};
        end else begin
          next_tcnt = tcnt - 8'h01;
        end
      end
      stepper_out_pkg::SER_HIGH: begin
        if (tcnt != 8'h00) begin
          next_tcnt = tcnt - 8'h01;
        end else if (bidx == frame_len_in) begin
          next_st   = stepper_out_pkg::SER_HOLD;
          next_tcnt = half;
        end else begin
          next_st   = stepper_out_pkg::SER_LOW;
          next_tcnt = half;
          next_bidx = bidx + 6'h01;
          next_drv  = nxm ? drv + 2'h1 : drv;
          next_sdo  = pick_bit(bidx[0] ? cfg_mem[bidx[5:1] + 5'h01][4:0] : word[10:6],
                               nxm ? drv + 2'h1 : drv, signal_bits_in);
        end
      end
      stepper_out_pkg::SER_HOLD: begin
        if (tcnt == 8'h00) begin
          next_st   = stepper_out_pkg::SER_IDLE;
          // idle picks the first bit from the entry at bidx, so rewind it here
          next_bidx = 6'h00;
          next_done = 1'b1;
        end else begin
          next_tcnt = tcnt - 8'h01;
        end
      end
      default: next_st = stepper_out_pkg::SER_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st   <= stepper_out_pkg::SER_IDLE;
      tcnt <= 8'h00;
      bidx <= 6'h00;
      drv  <= 2'h0;
      rx   <= 64'h0;
      sdo  <= 1'b0;
      done <= 1'b0;
    end else begin
      st   <= next_st;
      tcnt <= next_tcnt;
      bidx <= next_bidx;
      drv  <= next_drv;
      rx   <= next_rx;
      sdo  <= next_sdo;
      done <= next_done;
    end
  end

  // ==========================================================
  // registered pins
  // ==========================================================
  logic active;
  assign active = (st != stepper_out_pkg::SER_IDLE);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      driver_chip_select_n_out <= 1'b1;
      driver_clock_out         <= 1'b0;
      driver_chain_output_out  <= 1'b0;
      chain_readback_out       <= 64'h0;
      frame_done_out           <= 1'b0;
    end else begin
      driver_chip_select_n_out <= active ~^ cs_active_high_in;
      driver_clock_out         <= (st == stepper_out_pkg::SER_HIGH) ^ sck_idle_high_in;
      driver_chain_output_out  <= sdo;
      frame_done_out           <= done;
      if (done) begin
        chain_readback_out <= rx;
      end
    end
  end
endmodule : stepper_driver_output_port
`default_nettype wire

// ==== tb/stepper_out_properties.sv ====
`default_nettype none
module stepper_out_properties (
  input wire logic       mclk_in,
  input wire logic       rst_in,
  input wire logic       step_dir_select_in,
  input wire logic [3:0] secondary_clock_divider_in,
  input wire logic [7:0] sck_divider_in,
  input wire logic       cs_active_high_in,
  input wire logic       sck_idle_high_in,
  input wire logic [5:0] frame_len_in,
  input wire logic       step_out,
  input wire logic       dir_out,
  input wire logic       driver_chip_select_n_out,
  input wire logic       driver_clock_out,
  input wire logic       frame_done_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] hi_cnt, gap_cnt, dir_cnt, half_cnt, plen, half;
  logic [6:0] bit_cnt;
  logic       st_q, clk_q, dir_q, cs_q, cs_act;
  assign cs_act = (driver_chip_select_n_out == cs_active_high_in);
  assign plen = {2'h0, secondary_clock_divider_in, 4'h0} + 10'h010;
  assign half = ((sck_divider_in < 8'h07) ? 10'h007 : {2'h0, sck_divider_in}) + 10'h001;
  // gap and direction counters saturate so a long idle never fakes a short gap
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      {st_q, clk_q, dir_q, cs_q} <= 4'h0;
      {hi_cnt, half_cnt} <= 20'h00000;
      {gap_cnt, dir_cnt} <= 20'hFFFFF;
      bit_cnt <= 7'h00;
    end else begin
      {st_q, clk_q, dir_q, cs_q} <= {step_out, driver_clock_out, dir_out, cs_act};
      hi_cnt <= step_out ? hi_cnt + 10'h001 : 10'h000;
      gap_cnt <= (step_out && !st_q) ? 10'h001 : gap_cnt + {9'h000, gap_cnt != 10'h3FF};
      dir_cnt <= (dir_out != dir_q) ? 10'h000 : dir_cnt + {9'h000, dir_cnt != 10'h3FF};
      half_cnt <= (driver_clock_out != clk_q) ? 10'h001 : half_cnt + 10'h001;
      if (cs_act && !cs_q) bit_cnt <= 7'h00;
      else if (driver_clock_out != sck_idle_high_in && clk_q == sck_idle_high_in)
        bit_cnt <= bit_cnt + 7'h01;
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  property p_step_mode; (step_out && !st_q) |-> step_dir_select_in; endproperty
  a_step_mode: assert property (p_step_mode) else $error("step in serial mode");
  property p_pulse_len; (!step_out && st_q) |-> hi_cnt == plen; endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length");
  property p_dir_wait; (step_out && !st_q) |-> dir_cnt >= plen - 10'h001; endproperty
  a_dir_wait: assert property (p_dir_wait) else $error("direction setup");
  property p_rate; (step_out && !st_q) |-> gap_cnt >= 10'h020; endproperty
  a_rate: assert property (p_rate) else $error("step rate");
  property p_dir_quiet; (dir_out != dir_q) |-> !step_out && !st_q; endproperty
  a_dir_quiet: assert property (p_dir_quiet) else $error("dir moved in pulse");
  property p_half;
    cs_act && bit_cnt != 7'h00 && driver_clock_out != clk_q
      && driver_clock_out == sck_idle_high_in |-> half_cnt == half;
  endproperty
  a_half: assert property (p_half) else $error("clock phase");
  property p_bits; frame_done_out |-> bit_cnt == {1'b0, frame_len_in} + 7'h01; endproperty
  a_bits: assert property (p_bits) else $error("frame bit count");
  property p_idle;
    frame_done_out |=> !cs_act && driver_clock_out == sck_idle_high_in;
  endproperty
  a_idle: assert property (p_idle) else $error("idle levels");
endmodule : stepper_out_properties
bind stepper_driver_output_port stepper_out_properties i_stepper_out_properties (
  .mclk_in(mclk_in), .rst_in(rst_in), .step_dir_select_in(step_dir_select_in),
  .secondary_clock_divider_in(secondary_clock_divider_in), .sck_divider_in(sck_divider_in),
  .cs_active_high_in(cs_active_high_in), .sck_idle_high_in(sck_idle_high_in),
  .frame_len_in(frame_len_in), .step_out(step_out), .dir_out(dir_out),
  .driver_chip_select_n_out(driver_chip_select_n_out), .driver_clock_out(driver_clock_out),
  .frame_done_out(frame_done_out));
`default_nettype wire

// ==== tb/driver_chain_model.sv ====
`default_nettype none
module driver_chain_model (
  input  wire logic        mclk_in,
  input  wire logic        cs_n_in,
  input  wire logic        sck_in,
  input  wire logic        sdo_in,
  input  wire logic        cs_active_high_in,
  input  wire logic        sck_idle_high_in,
  input  wire logic [5:0]  len_in,
  input  wire logic [63:0] reply_in,
  output logic             sdi_out,
  output logic [63:0]      rx_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       act_q, sck_q;
  logic [5:0] idx;
  initial {sdi_out, rx_out, act_q, sck_q, idx} = {1'b1, 72'h0};
  always @(posedge mclk_in) begin
    act_q <= (cs_n_in == cs_active_high_in);
    sck_q <= sck_in;
    // pull-up level whenever the chain is not selected
    if (cs_n_in != cs_active_high_in) sdi_out <= 1'b1;
    else if (!act_q) begin
      sdi_out <= reply_in[len_in];
      idx <= len_in;
    end else if (sck_in != sck_idle_high_in && sck_q == sck_idle_high_in)
      rx_out <= {rx_out[62:0], sdo_in};
    else if (sck_in == sck_idle_high_in && sck_q != sck_idle_high_in) begin
      sdi_out <= (idx == 6'h00) ? ~sdi_out : reply_in[idx - 6'h01];
      idx <= idx - 6'h01;
    end
  end
endmodule : driver_chain_model
`default_nettype wire

// ==== tb/stepper_driver_output_port_tb.sv ====
`default_nettype none
module stepper_driver_output_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] PAT = 32'hA5C3_0F96;
  logic        mclk_in, rst_in, sel, step_req, dir_req, cs_hi, idle_hi, we, chain_en;
  logic        sdi, step, dir, busy, cs_n, sck, sdo, done;
  logic [3:0]  div2;
  logic [7:0]  sck_div;
  logic [5:0]  len;
  logic [4:0]  addr;
  logic [11:0] wdata;
  logic [2:0]  sig [0:2][0:31];
  logic [63:0] rback, rx, reply;
  int          err_total = 0;
  int          check_count = 0;
  int          lat, hi;
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  stepper_driver_output_port i_stepper_driver_output_port (
    .mclk_in(mclk_in), .rst_in(rst_in), .step_dir_select_in(sel),
    .secondary_clock_divider_in(div2), .step_req_in(step_req), .dir_req_in(dir_req),
    .sck_divider_in(sck_div), .cs_active_high_in(cs_hi), .sck_idle_high_in(idle_hi),
    .frame_len_in(len), .cfg_we_in(we), .cfg_addr_in(addr), .cfg_data_in(wdata),
    .chain_enable_in(chain_en), .signal_bits_in(sig), .driver_chain_input_in(sdi),
    .step_out(step), .dir_out(dir), .step_busy_out(busy), .driver_chip_select_n_out(cs_n),
    .driver_clock_out(sck), .driver_chain_output_out(sdo), .chain_readback_out(rback),
    .frame_done_out(done));
  driver_chain_model i_driver_chain_model (
    .mclk_in(mclk_in), .cs_n_in(cs_n), .sck_in(sck), .sdo_in(sdo), .cs_active_high_in(cs_hi),
    .sck_idle_high_in(idle_hi), .len_in(len), .reply_in(reply), .sdi_out(sdi), .rx_out(rx));
  task check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task print_verdict;
    $display("mismatches %0d of %0d checks", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task wait_step(input logic v, inout int c);
    while (step !== v && c < 2000) begin
      @(posedge mclk_in);
      c++;
    end
  endtask : wait_step
  task step_once(input logic [3:0] n, input logic d);
    lat = 0;
    hi = 0;
    while (busy !== 1'b0 && lat < 600) begin
      @(posedge mclk_in);
      lat++;
    end
    @(posedge mclk_in);
    {div2, dir_req, step_req} <= {n, d, 1'b1};
    lat = 0;
    wait_step(1'b1, lat);
    step_req <= 1'b0;
    wait_step(1'b0, hi);
  endtask : step_once
  task frame(input logic [5:0] n, input logic [7:0] d, input logic ch, input logic ih,
             input logic [63:0] flip);
    int c;
    logic [63:0] exp;
    c = 0;
    exp = '0;
    @(posedge mclk_in);
    {len, sck_div, cs_hi, idle_hi} <= {n, d, ch, ih};
    reply <= {PAT, ~PAT} ^ {58'h0, n};
    repeat (3) @(posedge mclk_in);
    chain_en <= 1'b1;
    @(posedge mclk_in);
    chain_en <= 1'b0;
    while (done !== 1'b1 && c < 40000) begin
      @(posedge mclk_in);
      c++;
    end
    for (int k = 0; k <= n; k++) exp[n - k] = PAT[k % 32];
    check(rx & ({64{1'b1}} >> (6'h3F - n)), exp ^ flip);
    check(rback & ({64{1'b1}} >> (6'h3F - n)), reply & ({64{1'b1}} >> (6'h3F - n)));
    @(posedge mclk_in);
    check({62'h0, cs_n, sck}, {62'h0, ~ch, ih});
  endtask : frame
  initial begin
    {rst_in, sel, step_req, dir_req, cs_hi, idle_hi, we, chain_en} = 8'h80;
    {div2, sck_div, len, addr, wdata, reply} = '0;
    for (int d = 0; d < 3; d++)
      for (int c = 0; c < 32; c++) sig[d][c] = {d[1:0], PAT[c] ^ d[0]};
    repeat (4) @(posedge mclk_in);
    check({61'h0, cs_n, sck, step}, {61'h0, 3'b100});
    rst_in <= 1'b0;
    // table word i holds entries 2i and 2i+1, codes chosen as entry mod 32
    for (int i = 0; i < 32; i++) begin
      @(posedge mclk_in);
      {we, addr, wdata} <= {1'b1, 5'(i), 1'b0, 5'(2 * i + 1), 1'b0, 5'(2 * i)};
    end
    @(posedge mclk_in);
    {we, sel} <= 2'b01;
    for (int k = 0; k < 4; k++) begin
      step_once(4'(k * 5), 1'b0);
      check(64'(hi), 64'(16 * (k * 5 + 1)));
    end
    step_once(4'h2, 1'b1);
    check({63'h0, dir}, 64'h1);
    check(64'(lat >= 48), 64'h1);
    // shortest pulse divider for the top rate
    step_once(4'h0, 1'b1);
    check({63'h0, busy}, 64'h1);
    step_req <= 1'b1;
    lat = 0;
    wait_step(1'b0, lat);
    wait_step(1'b1, lat);
    check(64'(lat + hi >= 32), 64'h1);
    // let the running pulse end so only new requests are counted below
    wait_step(1'b0, lat);
    sel <= 1'b0;
    hi = 0;
    repeat (64) begin
      @(posedge mclk_in);
      hi += int'(step === 1'b1);
    end
    step_req <= 1'b0;
    check(64'(hi), 64'h0);
    frame(6'h3F, 8'h07, 1'b0, 1'b0, 64'h0);
    frame(6'h00, 8'h03, 1'b1, 1'b1, 64'h0);
    frame(6'h08, 8'h0F, 1'b0, 1'b1, 64'h0);
    frame(6'h02, 8'hFF, 1'b1, 1'b0, 64'h0);
    // entries 0 and 1 advance the driver: bits go to drivers 0, 1, 2
    @(posedge mclk_in);
    {we, addr, wdata} <= {1'b1, 5'h00, 12'h860};
    @(posedge mclk_in);
    we <= 1'b0;
    frame(6'h02, 8'h07, 1'b0, 1'b0, 64'h2);
    print_verdict;
  end
  initial begin
    #400000;
    err_total++;
    print_verdict;
  end
endmodule : stepper_driver_output_port_tb
`default_nettype wire
